// *** hdl/lcrd_ctrl.sv ***
// Light control brightness range derivation and disable state machine with APB registers
`timescale 1ns/100ps

module lcrd_ctrl #(
    parameter int NCHAN    = 3,
    parameter int TICK_CYC = lcrd_pkg::LCRD_TICK_CYC
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               superimposed,
    input  wire logic               presence_in,
    output lcrd_pkg::lcrd_tel_t     tel,
    output logic                    disable_status,
    output logic                    status_tx,
    output logic                    lc_active,
    output logic                    presence_int,
    output logic                    startup_req,
    output logic [7:0]              startup_out,
    output logic [7:0]              step_size,
    output logic                    step_due
);
    import lcrd_pkg::*;

    typedef enum {
        LCRD_ST_ENABLED,
        LCRD_ST_SEND,
        LCRD_ST_STEPDOWN,
        LCRD_ST_DISABLED,
        LCRD_ST_ENDOFF
    } lcrd_state_t;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] cfg;
    logic [10:0] setpoint;
    logic [10:0] max_user;
    logic [10:0] low_user;
    logic [7:0]  extra_s;
    logic        dis_own;
    logic        dis_fb1;
    logic [10:0] bright;
    logic [7:0]  start_val [NCHAN];
    lcrd_state_t state;
    logic [1:0]  chan_cnt;
    logic [23:0] tick_cnt;
    logic [8:0]  sec_cnt;
    logic [3:0]  gap_cnt;
    logic        dis_q;
    logic        stat_q;
    logic        sp_err;
    logic        pres_s1;
    logic        pres_s2;
    logic        sup_s1;
    logic        sup_s2;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire bus_wr   = psel && penable && pwrite;
    wire bus_rd   = psel && !penable && !pwrite;
    wire hit_cfg  = paddr == LCRD_OFF_CFG;
    wire hit_sp   = paddr == LCRD_OFF_SETPOINT;
    wire hit_max  = paddr == LCRD_OFF_MAXILL;
    wire hit_low  = paddr == LCRD_OFF_LOWTH;
    wire hit_cmd  = paddr == LCRD_OFF_CMD;
    wire hit_st   = paddr == LCRD_OFF_STATUS;
    wire hit_eff  = paddr == LCRD_OFF_EFFECT;
    wire hit_br   = paddr == LCRD_OFF_BRIGHT;
    wire hit_ext  = paddr == LCRD_OFF_EXTRA;
    wire hit_val  = paddr[7:4] == 4'h3 && paddr[1:0] == 2'b00 && 32'(paddr[3:2]) < NCHAN;
    wire mapped   = hit_cfg | hit_sp | hit_max | hit_low | hit_cmd | hit_st
                  | hit_eff | hit_br | hit_ext | hit_val;

    // ------------------------------------------------------------------
    // Setpoint acceptance
    // ------------------------------------------------------------------
    wire         user_dyn = cfg[LCRD_CFG_USERDYN];
    wire [10:0]  wsp      = pwdata[10:0];
    wire [10:0]  sp_rem   = wsp % LCRD_STD_SP_STEP;
    wire         sp_std_ok = wsp >= LCRD_STD_SP_MIN && wsp <= LCRD_STD_SP_MAX
                          && (wsp < LCRD_STD_SP_STEP || sp_rem == 11'h000);
    wire         sp_usr_ok = wsp >= LCRD_USR_MIN && wsp <= LCRD_USR_MAX;
    wire         sp_ok     = user_dyn ? sp_usr_ok : sp_std_ok;
    wire         max_ok    = wsp >= LCRD_USR_MIN && wsp <= LCRD_USR_MAX;
    wire         low_ok    = wsp <= LCRD_USR_MAX;

    // ------------------------------------------------------------------
    // Effective range: 1.2 x setpoint is 6/5, kept exact in 14 bits
    // ------------------------------------------------------------------
    wire [13:0]  sp_x6    = 14'(setpoint) * 14'h0006;
    wire [10:0]  max_std  = 11'(sp_x6 / 14'h0005);
    lcrd_range_t range;
    assign range.max_ill  = user_dyn ? max_user : max_std;
    assign range.low_th   = user_dyn ? low_user : LCRD_LOWTH_RST;

    // Control characteristics derived from the range
    wire         below_th = bright < range.low_th;
    wire [10:0]  gap_lux  = bright < setpoint ? setpoint - bright : bright - setpoint;
    // Divisor guard only for a zero maximum; only a setpoint of 1707 under standard dynamic reaches it, as max_std wraps to 0
    wire [10:0]  div_ill  = range.max_ill == 11'h000 ? 11'h001 : range.max_ill;
    wire [18:0]  gap_sc   = {gap_lux, 8'h00} / {8'h00, div_ill};
    wire [7:0]   next_step = gap_sc > 19'h0000FF ? 8'hFF : gap_sc[7:0];
    wire [18:0]  su_sc    = {setpoint, 8'h00} / {8'h00, div_ill};
    wire [7:0]   next_su  = su_sc > 19'h0000FF ? 8'hFF : su_sc[7:0];
    wire [3:0]   gap_lim  = below_th ? 4'(LCRD_TX_GAP_FAST) : 4'(LCRD_TX_GAP_CYC);

    // ------------------------------------------------------------------
    // Disable source and change detection
    // ------------------------------------------------------------------
    wire         dis_cmd  = cfg[LCRD_CFG_COMBINED] ? dis_fb1 : dis_own;
    wire         dis_rise = dis_cmd && !dis_q;
    wire         dis_fall = !dis_cmd && dis_q;
    wire         start_sel_send = cfg[LCRD_CFG_START_LO +: 2] == LCRD_START_SEND;
    wire         start_sel_step = cfg[LCRD_CFG_START_LO +: 2] == LCRD_START_STEP;
    wire [1:0]   end_sel  = cfg[LCRD_CFG_END_LO +: 2];
    wire         tick     = tick_cnt == 24'(TICK_CYC - 1);
    wire [8:0]   wait_s   = 9'(LCRD_STEPDOWN_S) + {1'b0, extra_s};
    wire         next_stat = cfg[LCRD_CFG_STAT_EN] && (dis_cmd || sup_s2);
    wire         last_ch  = 32'(chan_cnt) == NCHAN - 1;

    // ------------------------------------------------------------------
    // Register writes; a write of the current disable value changes nothing
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg      <= LCRD_CFG_RST;
            setpoint <= LCRD_SETPOINT_RST;
            max_user <= LCRD_MAXILL_RST;
            low_user <= LCRD_LOWTH_RST;
            extra_s  <= LCRD_EXTRA_RST;
            dis_own  <= 1'b0;
            dis_fb1  <= 1'b0;
            bright   <= 11'h000;
            sp_err   <= 1'b0;
        end else if (bus_wr) begin
            if (hit_cfg) cfg <= pwdata;
            if (hit_sp) begin
                if (sp_ok) setpoint <= wsp;
                sp_err <= !sp_ok;
            end
            if (hit_max && max_ok && user_dyn) max_user <= wsp;
            if (hit_low && low_ok && user_dyn) low_user <= wsp;
            if (hit_ext) extra_s <= pwdata[7:0];
            if (hit_br)  bright  <= wsp;
            if (hit_cmd) begin
                dis_own <= pwdata[0];
                dis_fb1 <= pwdata[1];
            end
        end
    end

    // Start telegram values per channel, one register each
    generate
        for (genvar g = 0; g < NCHAN; g++) begin : g_val
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) start_val[g] <= 8'h00;
                else if (bus_wr && hit_val && 32'(paddr[3:2]) == g) start_val[g] <= pwdata[7:0];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Input synchronisers for pins from outside
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pres_s1 <= 1'b0;
            pres_s2 <= 1'b0;
            sup_s1  <= 1'b0;
            sup_s2  <= 1'b0;
        end else begin
            pres_s1 <= presence_in;
            pres_s2 <= pres_s1;
            sup_s1  <= superimposed;
            sup_s2  <= sup_s1;
        end
    end

    // ------------------------------------------------------------------
    // Forced disable is tested only at the first edge after release, while cfg still holds its reset value 0, so it never applies
    // ------------------------------------------------------------------
    logic boot;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) boot <= 1'b1;
        else          boot <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Disable state machine
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state        <= LCRD_ST_ENABLED;
            dis_q        <= 1'b0;
            chan_cnt     <= 2'b00;
            tick_cnt     <= 24'h000000;
            sec_cnt      <= 9'h000;
            tel          <= '0;
            presence_int <= 1'b0;
            startup_req  <= 1'b0;
        end else begin
            tel.valid   <= 1'b0;
            startup_req <= 1'b0;
            dis_q       <= dis_cmd || (boot && cfg[LCRD_CFG_FORCE]);
            // Restart the second count at disabling so the wait is whole seconds
            tick_cnt    <= (tick || dis_rise) ? 24'h000000 : tick_cnt + 24'h000001;
            if (boot && cfg[LCRD_CFG_FORCE]) begin
                state <= LCRD_ST_DISABLED;
            end else if (dis_fall) begin
                // Abort any reaction and apply the end reaction; presence cleared except on startup
                presence_int <= 1'b0;
                chan_cnt     <= 2'b00;
                unique case (end_sel)
                    LCRD_END_OFF: state <= LCRD_ST_ENDOFF;
                    LCRD_END_STARTUP: begin
                        presence_int <= 1'b1;
                        startup_req  <= bright < setpoint;
                        state        <= LCRD_ST_ENABLED;
                    end
                    default: state <= LCRD_ST_ENABLED;
                endcase
            end else if (dis_rise) begin
                chan_cnt <= 2'b00;
                sec_cnt  <= 9'h000;
                if (start_sel_send)      state <= LCRD_ST_SEND;
                else if (start_sel_step) state <= LCRD_ST_STEPDOWN;
                else                     state <= LCRD_ST_DISABLED;
            end else begin
                unique case (state)
                    LCRD_ST_SEND: begin
                        tel.valid    <= 1'b1;
                        tel.chan     <= chan_cnt;
                        tel.is_value <= !cfg[LCRD_CFG_SWMASK + 32'(chan_cnt)];
                        tel.data     <= start_val[chan_cnt];
                        chan_cnt     <= chan_cnt + 2'b01;
                        if (last_ch) state <= LCRD_ST_DISABLED;
                    end
                    LCRD_ST_STEPDOWN: begin
                        // Presence is not looked at while waiting
                        if (tick) sec_cnt <= sec_cnt + 9'h001;
                        if (tick && sec_cnt + 9'h001 >= wait_s) begin
                            tel.valid    <= 1'b1;
                            tel.chan     <= 2'b00;
                            tel.is_value <= 1'b0;
                            tel.data     <= 8'h00;
                            state        <= LCRD_ST_DISABLED;
                        end
                    end
                    LCRD_ST_ENDOFF: begin
                        tel.valid    <= 1'b1;
                        tel.chan     <= chan_cnt;
                        tel.is_value <= 1'b0;
                        tel.data     <= 8'h00;
                        chan_cnt     <= chan_cnt + 2'b01;
                        if (last_ch) state <= LCRD_ST_ENABLED;
                    end
                    LCRD_ST_ENABLED: begin
                        // Presence restarts control from measured brightness
                        if (pres_s2 && !presence_int) startup_req <= bright < setpoint;
                        presence_int <= presence_int | pres_s2;
                    end
                    LCRD_ST_DISABLED: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Control pacing and derived outputs; pacing idle when disabled
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt     <= 4'h0;
            step_due    <= 1'b0;
            step_size   <= 8'h00;
            startup_out <= 8'h00;
            lc_active   <= 1'b0;
        end else begin
            lc_active   <= state == LCRD_ST_ENABLED && !dis_cmd && !sup_s2;
            step_size   <= next_step;
            startup_out <= next_su;
            step_due    <= lc_active && gap_cnt >= gap_lim;
            gap_cnt     <= (!lc_active || gap_cnt >= gap_lim) ? 4'h0 : gap_cnt + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Disable status and its transmission on change
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q         <= 1'b0;
            disable_status <= 1'b0;
            status_tx      <= 1'b0;
        end else begin
            stat_q         <= next_stat;
            disable_status <= next_stat;
            status_tx      <= cfg[LCRD_CFG_STAT_TX] && next_stat != stat_q;
        end
    end

    // ------------------------------------------------------------------
    // APB read data, one wait-free access phase; unmapped answers an error
    // ------------------------------------------------------------------
    logic [31:0] next_rd;
    always_comb begin
        next_rd = 32'h0000_0000;
        if (hit_cfg) next_rd = cfg;
        if (hit_sp)  next_rd = {20'h00000, sp_err, setpoint};
        if (hit_max) next_rd = {21'h000000, max_user};
        if (hit_low) next_rd = {21'h000000, low_user};
        if (hit_cmd) next_rd = {30'h00000000, dis_fb1, dis_own};
        if (hit_st)  next_rd = {24'h000000, 3'(state), presence_int, sup_s2, lc_active,
                                 dis_q, disable_status};
        if (hit_eff) next_rd = {5'h00, range.low_th, 5'h00, range.max_ill};
        if (hit_br)  next_rd = {21'h000000, bright};
        if (hit_ext) next_rd = {24'h000000, extra_s};
        if (hit_val) next_rd = {24'h000000, start_val[paddr[3:2]]};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            if (psel && !penable) prdata <= bus_rd ? next_rd : 32'h0000_0000;
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

endmodule : lcrd_ctrl

// *** inc/lcrd_pkg.sv ***
// Package: register map, field layouts and timing constants of the light control range/disable block
package lcrd_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] LCRD_OFF_CFG      = 8'h00; // Dynamic and reaction options
    localparam logic [7:0] LCRD_OFF_SETPOINT = 8'h04; // Setpoint in lux
    localparam logic [7:0] LCRD_OFF_MAXILL   = 8'h08; // User max illuminance
    localparam logic [7:0] LCRD_OFF_LOWTH    = 8'h0C; // User lower threshold
    localparam logic [7:0] LCRD_OFF_CMD      = 8'h10; // Disable command, inputs
    localparam logic [7:0] LCRD_OFF_STATUS   = 8'h14; // Block state
    localparam logic [7:0] LCRD_OFF_EFFECT   = 8'h18; // Effective range values
    localparam logic [7:0] LCRD_OFF_BRIGHT   = 8'h1C; // Measured brightness
    localparam logic [7:0] LCRD_OFF_EXTRA    = 8'h20; // Extra step-down wait, seconds

    // ------------------------------------------------------------------
    // Field positions of the configuration register
    // ------------------------------------------------------------------
    localparam int LCRD_CFG_USERDYN  = 0;  // 1: user-defined dynamic
    localparam int LCRD_CFG_START_LO = 1;  // 2 bits: start reaction
    localparam int LCRD_CFG_END_LO   = 3;  // 2 bits: end reaction
    localparam int LCRD_CFG_COMBINED = 5;  // 1: disable taken from block one
    localparam int LCRD_CFG_FORCE    = 6;  // force disable bit; read only at the first edge after reset, when it is still 0
    localparam int LCRD_CFG_STAT_EN  = 7;  // 1: status output enabled
    localparam int LCRD_CFG_STAT_TX  = 8;  // 1: transmit status on change
    localparam int LCRD_CFG_SWMASK   = 9;  // 3 bits: start telegram switch values

    // Reset values
    localparam logic [31:0] LCRD_CFG_RST      = 32'h0000_0000;
    localparam logic [10:0] LCRD_SETPOINT_RST = 11'h1F4;  // 500 lux
    localparam logic [10:0] LCRD_MAXILL_RST   = 11'h258;  // 600 lux
    localparam logic [10:0] LCRD_LOWTH_RST    = 11'h000;
    localparam logic [7:0]  LCRD_EXTRA_RST    = 8'h00;

    // Lux limits
    localparam logic [10:0] LCRD_STD_SP_MIN  = 11'h014;  // 20
    localparam logic [10:0] LCRD_STD_SP_MAX  = 11'h3E8;  // 1000
    localparam logic [10:0] LCRD_STD_SP_STEP = 11'h032;  // 50
    localparam logic [10:0] LCRD_USR_MIN     = 11'h00A;  // 10
    localparam logic [10:0] LCRD_USR_MAX     = 11'h7D0;  // 2000

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int LCRD_CLK_HZ        = 10_000_000;
    localparam int LCRD_STEPDOWN_S    = 10;        // Fixed step-down wait
    localparam int LCRD_TICK_CYC      = LCRD_CLK_HZ; // One second of pclk
    localparam int LCRD_TX_GAP_CYC    = 8;         // Normal telegram spacing
    localparam int LCRD_TX_GAP_FAST   = 2;         // Spacing below threshold

    // Reaction encodings
    typedef enum logic [1:0] {
        LCRD_START_SILENT = 2'b00,
        LCRD_START_SEND   = 2'b01,
        LCRD_START_STEP   = 2'b10
    } lcrd_start_t;

    typedef enum logic [1:0] {
        LCRD_END_SILENT  = 2'b00,
        LCRD_END_OFF     = 2'b01,
        LCRD_END_STARTUP = 2'b10
    } lcrd_end_t;

    // Outgoing telegram towards the bus
    typedef struct packed {
        logic       valid;
        logic [1:0] chan;
        logic       is_value;  // 1: brightness value, 0: switch
        logic [7:0] data;
    } lcrd_tel_t;

    // Effective range parameters
    typedef struct packed {
        logic [10:0] max_ill;
        logic [10:0] low_th;
    } lcrd_range_t;

endpackage : lcrd_pkg

// *** dv/lcrd_actuator_model.sv ***
// Telegram sink standing in for the bus actuators
`timescale 1ns/100ps
module lcrd_actuator_model (
    input  wire lcrd_pkg::lcrd_tel_t tel,
    input  wire logic                pclk,
    input  wire logic                presetn,
    output logic [7:0]               n_tel,
    output logic [7:0]               last_data
);
    import lcrd_pkg::*;
    // One valid pulse is one whole telegram; the data of channel 0 is kept in last_data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_tel     <= 8'h00;
            last_data <= 8'h00;
        end else if (tel.valid) begin
            n_tel     <= n_tel + 8'h01;
            if (tel.chan == 2'b00) last_data <= tel.data;
        end
    end
endmodule : lcrd_actuator_model

// *** dv/lcrd_ctrl_properties.sv ***
// Port-level assertions of the light control range/disable block
`timescale 1ns/100ps
module lcrd_ctrl_checker (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic [31:0]         prdata,
    input  wire logic                pready,
    input  wire logic                pslverr,
    input  wire logic                superimposed,
    input  wire lcrd_pkg::lcrd_tel_t tel,
    input  wire logic                disable_status,
    input  wire logic                status_tx,
    input  wire logic                lc_active,
    input  wire logic                presence_int,
    input  wire logic                startup_req,
    input  wire logic                step_due
);
    import lcrd_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus: no wait states, refused places read as zero
    a_ready_next: assert property (psel && !penable |=> pready && penable)
        else $error("ready missing after setup");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    // Disabled or overridden controller stays passive; sync delay is two stages
    a_status_idle: assert property (disable_status |-> !lc_active)
        else $error("active while disabled");
    a_super_stops: assert property (superimposed [*5] |-> !lc_active)
        else $error("active during superimposed operation");
    a_chan_range: assert property (tel.valid |-> tel.chan < 2'h3)
        else $error("telegram on missing channel");
    // Fast spacing still leaves two quiet cycles
    a_step_gap: assert property (step_due |=> !step_due [*2])
        else $error("control telegrams too close");
    a_startup_pres: assert property (startup_req |-> ##[0:2] presence_int)
        else $error("startup without presence");
    a_tx_change: assert property (status_tx |-> disable_status != $past(disable_status))
        else $error("status sent without change");
endmodule : lcrd_ctrl_checker

bind lcrd_ctrl lcrd_ctrl_checker u_lcrd_ctrl_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .superimposed(superimposed), .tel(tel), .disable_status(disable_status),
    .status_tx(status_tx), .lc_active(lc_active), .presence_int(presence_int),
    .startup_req(startup_req), .step_due(step_due));

// *** dv/test_lcrd_ctrl.sv ***
// Self-checking bench of the light control range/disable block
`timescale 1ns/100ps
module test_lcrd_ctrl;
    import lcrd_pkg::*;
    localparam int TICK = 10; // Ten cycles stand for one second to keep runs short
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic                superimposed, presence_in, disable_status, status_tx;
    logic                lc_active, presence_int, startup_req, step_due;
    logic [7:0]          paddr, n_tel, last_data, su, ss;
    logic [31:0]         pwdata, prdata, r;
    lcrd_tel_t           tel;
    int                  n_fail, num_checks, cyc, sp, mx, lo, k;

    lcrd_ctrl #(.NCHAN(3), .TICK_CYC(TICK)) u_lcrd_ctrl (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .superimposed(superimposed),
        .presence_in(presence_in), .tel(tel), .disable_status(disable_status),
        .status_tx(status_tx), .lc_active(lc_active), .presence_int(presence_int),
        .startup_req(startup_req), .startup_out(su), .step_size(ss), .step_due(step_due));
    lcrd_actuator_model u_lcrd_actuator_model (.tel(tel), .pclk(pclk), .presetn(presetn),
        .n_tel(n_tel), .last_data(last_data));

    // Effective range word: maximum in the low field, threshold above
    function automatic logic [31:0] eff(input int m, input int l);
        return {5'h00, l[10:0], 5'h00, m[10:0]};
    endfunction : eff

    // Scaled control value: gap times 256 over the maximum, clipped to a byte
    function automatic int scl(input int g, input int m);
        return g * 256 / m > 255 ? 255 : g * 256 / m;
    endfunction : scl

    // APB master; holds the request until ready is seen at a rising edge, releases there
    task apb(input logic w, input logic [7:0] a, input int d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task chk(input string n, input logic [31:0] x, input logic [31:0] s);
        num_checks++;
        if (s !== x) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask : chk

    task results;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // Clock and hang guard; a hang counts as a mismatch
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            results();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, superimposed, presence_in} = 6'h00;
        paddr = 8'h00; pwdata = 32'h0; n_fail = 0; num_checks = 0; cyc = 0;
        void'($urandom(81844));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, LCRD_OFF_CFG, 0); chk("cfg", LCRD_CFG_RST, r);
        // Standard dynamic: limits, steps, derived maximum, refused writes
        for (k = 0; k < 6; k++) begin
            sp = k == 0 ? 1000 : k == 1 ? 20 : k % 2 ? 20 + $urandom % 30 : 50 * (1 + $urandom % 20);
            apb(1, LCRD_OFF_SETPOINT, sp); apb(1, LCRD_OFF_SETPOINT, 75);
            apb(1, LCRD_OFF_MAXILL, 1500);
            apb(0, LCRD_OFF_EFFECT, 0); chk("std range", eff(sp * 6 / 5, 0), r);
        end
        // User dynamic: random fields plus out-of-range writes that must not land
        apb(1, LCRD_OFF_CFG, 1);
        for (k = 0; k < 5; k++) begin
            sp = 10 + k * 497; mx = k ? sp + 1 + $urandom % (2000 - sp) : 2000;
            lo = k ? $urandom % sp : 0;
            apb(1, LCRD_OFF_MAXILL, mx); apb(1, LCRD_OFF_LOWTH, lo); apb(1, LCRD_OFF_MAXILL, 9);
            apb(1, LCRD_OFF_LOWTH, 2001); apb(1, LCRD_OFF_SETPOINT, sp);
            apb(0, LCRD_OFF_EFFECT, 0); chk("user range", eff(mx, lo), r);
            apb(0, LCRD_OFF_SETPOINT, 0); chk("user setpoint", sp, r & 32'h7FF);
            chk("startup out", scl(sp, mx), su); chk("step size", scl(sp, mx), ss);
        end
        apb(0, 8'h24, 0); chk("unmapped", 32'h1, {r[30:0], e});
        // Send on start, off on end, repeated command ignored
        apb(1, 8'h30, 32'h5A);
        apb(1, LCRD_OFF_CFG, 32'hF8A); apb(1, LCRD_OFF_CMD, 1); repeat (10) @(posedge pclk);
        chk("start tels", 3, n_tel); chk("status", 1, disable_status);
        chk("start value", 32'h5A, last_data);
        apb(1, LCRD_OFF_CMD, 1); repeat (10) @(posedge pclk); chk("repeat", 3, n_tel);
        apb(1, LCRD_OFF_CMD, 0); repeat (10) @(posedge pclk);
        chk("end tels", 6, n_tel); chk("off value", 0, last_data);
        // Silent start, startup on end in the dark
        apb(1, LCRD_OFF_CFG, 32'h90); apb(1, LCRD_OFF_BRIGHT, 0); apb(1, LCRD_OFF_CMD, 1);
        repeat (10) @(posedge pclk); chk("silent", 6, n_tel);
        apb(1, LCRD_OFF_CMD, 0); repeat (5) @(posedge pclk); chk("presence", 1, presence_int);
        // Combined source and timed step-down; presence must not cut it short
        apb(1, LCRD_OFF_CFG, 32'h24); apb(1, LCRD_OFF_EXTRA, 1); apb(1, LCRD_OFF_CMD, 1);
        apb(0, LCRD_OFF_STATUS, 0); chk("own ignored", 0, r[1]);
        apb(1, LCRD_OFF_CMD, 2); presence_in <= 1'b1;
        apb(0, LCRD_OFF_STATUS, 0); chk("block one", 1, r[1]);
        repeat (10 * TICK) @(posedge pclk); chk("still waiting", 6, n_tel);
        repeat (2 * TICK) @(posedge pclk); chk("step done", 7, n_tel);
        apb(1, LCRD_OFF_CMD, 0); presence_in <= 1'b0;
        // Superimposed operation alone raises the status
        apb(1, LCRD_OFF_CFG, 32'h80); superimposed <= 1'b1; repeat (6) @(posedge pclk);
        chk("super status", 1, disable_status);
        superimposed <= 1'b0; repeat (6) @(posedge pclk);
        results();
    end
endmodule : test_lcrd_ctrl
